// >>> hw/aecr_regs.sv
// Behaviour
// - I gain trim is unsigned nine-bit code in bits 15:7, linear.
// - Gain trim fields reset to 1_0000_0000, meaning no adjustment.
// - Gain changes act at once, no recalibration needed.
// - Extended bit 15 swaps converter outputs for the pattern generator.
// - Pattern generator works in every clocking and interleave mode.
// - Extended bit 14 skips termination trim and keeps data clock running.
// - Extended bit 13 interleaves both converters on one input.
// - Extended bit 12 picks I (0) or Q (1) input when interleaved.
// - Extended bit 10 tunes for input clocks below 900 MHz.
// - Q offset magnitude is eight bits 15:8, zero to about 45 mV.
// - Bit 7 sets offset sign: zero positive, one negative.
// - Q gain trim decodes exactly like I gain trim.
// - Fine phase is eight bits 15:8, zero to about 50 ps.
// - Coarse register bit 15 inverts sampling clock, resets to zero.
// - Coarse phase bits 14:10 add about 65 ps per step.
// - Intermediate phase bits 9:7 add about 11 ps per step.
// - Extended register at address 9, write-only, resets to 0x03ff.
// - Frame: 32 bits MSB first, header 0x001, address, sixteen data.
// - Bits sampled on shift clock rise while select is low.
// - Next frame may start on 33rd edge; contents survive power-down.
// - Registers ignored and frames refused outside extended mode.
`timescale 1ns/10ps
`default_nettype none
module aecr_regs
   import aecr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic extended_mode,
   input wire logic power_down,
   input wire logic serial_shift_clk,
   input wire logic serial_select_n,
   input wire logic serial_input_line,
   output aecr_ext_s ext_ctrl,
   output aecr_trim_s trim,
   output logic output_data_clock_keep,
   output logic frame_taken
);

   logic [3:0] pins_sync;
   logic mode_s;
   logic sclk_s;
   logic sel_n_s;
   logic serial_input_line_s;
   aecr_frame_s frame;

   logic [15:0] i_gain_trim_q;
   logic [15:0] extended_setup_q;
   logic [15:0] q_offset_trim_q;
   logic [15:0] q_gain_trim_q;
   logic [15:0] sample_phase_fine_q;
   logic [15:0] sample_phase_coarse_q;

   aecr_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in({extended_mode, serial_shift_clk, serial_select_n,
         serial_input_line}),
      .stable_out(pins_sync)
   );

   assign mode_s = pins_sync[3];
   assign sclk_s = pins_sync[2];
   assign sel_n_s = pins_sync[1];
   assign serial_input_line_s = pins_sync[0];

   // The mode pin is synchronised like the port pins, so a mode change
   // mid-frame cannot split one clock edge into two verdicts.
   aecr_shifter u_shift (
      .clk(clk),
      .rst_n(rst_n),
      .enable(mode_s),
      .select_n(sel_n_s),
      .shift_clk(sclk_s),
      .data_bit(serial_input_line_s),
      .frame(frame)
   );

   // Only mapped addresses store; reserved ones and the registers outside
   // this block drop the frame. Power-down does not touch contents.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         i_gain_trim_q <= RST_I_GAIN;
         extended_setup_q <= RST_EXT_SETUP;
         q_offset_trim_q <= RST_Q_OFFSET;
         q_gain_trim_q <= RST_Q_GAIN;
         sample_phase_fine_q <= RST_PHASE_FINE;
         sample_phase_coarse_q <= RST_PHASE_COARSE;
      end else if (frame.valid) begin
         unique case (frame.addr)
            ADDR_I_GAIN: i_gain_trim_q <= frame.data;
            ADDR_EXT_SETUP: extended_setup_q <= frame.data;
            ADDR_Q_OFFSET: q_offset_trim_q <= frame.data;
            ADDR_Q_GAIN: q_gain_trim_q <= frame.data;
            ADDR_PHASE_FINE: sample_phase_fine_q <= frame.data;
            ADDR_PHASE_COARSE: sample_phase_coarse_q <= frame.data;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_taken <= 1'b0;
      end else begin
         frame_taken <= frame.valid;
      end
   end

   // Controls reach the analog side one cycle after the store, with no
   // calibration request, so a gain change acts at once.
   // Outside extended mode every control reads as its reset value.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_ctrl <= '0;
         trim <= '0;
         output_data_clock_keep <= 1'b0;
      end else if (!mode_s) begin
         ext_ctrl <= '0;
         trim <= '0;
         trim.i_gain <= RST_I_GAIN[GAIN_MSB:GAIN_LSB];
         trim.q_gain <= RST_Q_GAIN[GAIN_MSB:GAIN_LSB];
         output_data_clock_keep <= 1'b0;
      end else begin
         // Pattern select holds in every clocking mode.
         ext_ctrl.pattern_output_enable <=
            extended_setup_q[EXT_PATTERN_BIT];
         ext_ctrl.termination_trim_skip <=
            extended_setup_q[EXT_TERM_SKIP_BIT];
         ext_ctrl.interleave_sampling_enable <=
            extended_setup_q[EXT_INTERLEAVE_BIT];
         ext_ctrl.interleave_input_pick <=
            extended_setup_q[EXT_PICK_BIT];
         ext_ctrl.low_clock_rate_tuning <=
            extended_setup_q[EXT_LOWCLK_BIT];
         output_data_clock_keep <=
            extended_setup_q[EXT_TERM_SKIP_BIT];
         trim.i_gain <= i_gain_trim_q[GAIN_MSB:GAIN_LSB];
         trim.q_gain <= q_gain_trim_q[GAIN_MSB:GAIN_LSB];
         trim.q_offset_mag <= q_offset_trim_q[OFS_MSB:OFS_LSB];
         trim.q_offset_negative <= q_offset_trim_q[OFS_SIGN];
         trim.phase_fine <= sample_phase_fine_q[FINE_MSB:FINE_LSB];
         trim.sample_clock_invert <= sample_phase_coarse_q[POL_BIT];
         trim.phase_coarse <=
            sample_phase_coarse_q[COARSE_MSB:COARSE_LSB];
         trim.phase_inter <=
            sample_phase_coarse_q[INTER_MSB:INTER_LSB];
      end
   end

   // Low filler bits and bit 11 are stored but drive nothing; the host
   // keeps them as documented.
   logic unused_ok;
   assign unused_ok = power_down;

endmodule : aecr_regs
`default_nettype wire

// >>> hw/aecr_pkg.sv
package aecr_pkg;

   localparam int FRAME_BITS = 32;
   localparam int HDR_BITS = 12;
   localparam logic [11:0] HDR_PATTERN = 12'h001;

   localparam logic [3:0] ADDR_I_GAIN = 4'h3;
   localparam logic [3:0] ADDR_EXT_SETUP = 4'h9;
   localparam logic [3:0] ADDR_Q_OFFSET = 4'ha;
   localparam logic [3:0] ADDR_Q_GAIN = 4'hb;
   localparam logic [3:0] ADDR_PHASE_FINE = 4'he;
   localparam logic [3:0] ADDR_PHASE_COARSE = 4'hf;

   localparam logic [15:0] RST_I_GAIN = 16'h807f;
   localparam logic [15:0] RST_EXT_SETUP = 16'h03ff;
   localparam logic [15:0] RST_Q_OFFSET = 16'h007f;
   localparam logic [15:0] RST_Q_GAIN = 16'h807f;
   localparam logic [15:0] RST_PHASE_FINE = 16'h00ff;
   localparam logic [15:0] RST_PHASE_COARSE = 16'h007f;

   localparam int GAIN_MSB = 15;
   localparam int GAIN_LSB = 7;
   localparam int OFS_MSB = 15;
   localparam int OFS_LSB = 8;
   localparam int OFS_SIGN = 7;
   localparam int FINE_MSB = 15;
   localparam int FINE_LSB = 8;
   localparam int POL_BIT = 15;
   localparam int COARSE_MSB = 14;
   localparam int COARSE_LSB = 10;
   localparam int INTER_MSB = 9;
   localparam int INTER_LSB = 7;
   localparam int EXT_PATTERN_BIT = 15;
   localparam int EXT_TERM_SKIP_BIT = 14;
   localparam int EXT_INTERLEAVE_BIT = 13;
   localparam int EXT_PICK_BIT = 12;
   localparam int EXT_LOWCLK_BIT = 10;

   typedef struct packed {
      logic pattern_output_enable;
      logic termination_trim_skip;
      logic interleave_sampling_enable;
      logic interleave_input_pick;
      logic low_clock_rate_tuning;
   } aecr_ext_s;

   typedef struct packed {
      logic [8:0] i_gain;
      logic [8:0] q_gain;
      logic [7:0] q_offset_mag;
      logic q_offset_negative;
      logic [7:0] phase_fine;
      logic sample_clock_invert;
      logic [4:0] phase_coarse;
      logic [2:0] phase_inter;
   } aecr_trim_s;

   typedef struct packed {
      logic valid;
      logic [3:0] addr;
      logic [15:0] data;
   } aecr_frame_s;

endpackage : aecr_pkg

// >>> hw/aecr_sync.sv
`timescale 1ns/10ps
`default_nettype none
module aecr_sync
   import aecr_pkg::*;
#(
   parameter int WIDTH = 3
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] stable_out
);

   // Three stages; a change counts once the second and third agree, so a
   // metastable first stage can never reach the frame logic.
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_agree
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               stable_out[g] <= 1'b0;
            end else if (s2_q[g] == s3_q[g]) begin
               stable_out[g] <= s3_q[g];
            end
         end
      end
   endgenerate

endmodule : aecr_sync
`default_nettype wire

// >>> hw/aecr_shifter.sv
`timescale 1ns/10ps
`default_nettype none
module aecr_shifter
   import aecr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic select_n,
   input wire logic shift_clk,
   input wire logic data_bit,
   output aecr_frame_s frame
);

   logic sclk_prev_q;
   logic [FRAME_BITS-1:0] shreg_q;
   logic [5:0] count_q;
   logic rise;

   assign rise = shift_clk && !sclk_prev_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= shift_clk;
      end
   end

   // Bits are taken on the rising shift clock edge while selected.
   // Outside extended mode the port stays idle and holds its count at 0.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shreg_q <= '0;
         count_q <= 6'h00;
      end else if (!enable || select_n) begin
         count_q <= 6'h00;
      end else if (rise) begin
         shreg_q <= {shreg_q[FRAME_BITS-2:0], data_bit};
         // A new frame starts on the 33rd edge without deselecting.
         if (count_q == 6'(FRAME_BITS - 1)) begin
            count_q <= 6'h00;
         end else begin
            count_q <= count_q + 6'h01;
         end
      end
   end

   // Frame reported only after the 32nd bit with a valid header.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame <= '0;
      end else begin
         frame.valid <= enable && !select_n && rise
            && count_q == 6'(FRAME_BITS - 1)
            && shreg_q[FRAME_BITS-2:FRAME_BITS-HDR_BITS-1]
               == HDR_PATTERN;
         frame.addr <= shreg_q[18:15];
         frame.data <= {shreg_q[14:0], data_bit};
      end
   end

endmodule : aecr_shifter
`default_nettype wire

// >>> testbench/aecr_regs_properties.sv
`timescale 1ns/10ps
`default_nettype none
module aecr_regs_properties
   import aecr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic extended_mode,
   input wire logic serial_select_n,
   input wire aecr_ext_s ext_ctrl,
   input wire aecr_trim_s trim,
   input wire logic output_data_clock_keep,
   input wire logic frame_taken
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_rst_gain: assert property (
      !$past(rst_n, 2) && $past(rst_n) |-> trim.i_gain == 9'h100
      && trim.q_gain == 9'h100) else $error("gain reset wrong");
   a_rst_rest: assert property (
      !$past(rst_n, 2) && $past(rst_n) |-> ext_ctrl == '0
      && {trim.sample_clock_invert, trim.phase_coarse} == '0)
      else $error("setup reset wrong");
   // The keep flag may only move after a frame or a synchronised mode
   // change, which reaches the outputs five samples after the pin.
   a_keep_mirror: assert property (
      output_data_clock_keep == ext_ctrl.termination_trim_skip
      && (!$changed(output_data_clock_keep) || $past(frame_taken)
      || $past(extended_mode, 5) != $past(extended_mode, 6)))
      else $error("keep flag wrong");
   a_mode_dflt: assert property (
      (!extended_mode) [*6] |-> ext_ctrl == '0 && trim.i_gain == 9'h100)
      else $error("defaults not shown");
   a_mode_quiet: assert property (
      (!extended_mode) [*8] |-> !frame_taken)
      else $error("frame taken off mode");
   a_pulse_gap: assert property (
      frame_taken |=> (!frame_taken) [*8]) else $error("pulses too close");
   a_sel_quiet: assert property (
      serial_select_n [*8] |-> ##4 !frame_taken)
      else $error("frame taken deselected");
   // Outputs follow a store on the same edge that ends the frame pulse.
   a_hold_still: assert property (
      extended_mode [*7] ##0 ($past(rst_n, 2) && !$past(frame_taken))
      |-> $stable(trim) && $stable(ext_ctrl))
      else $error("outputs moved alone");
   c_frame: cover property (frame_taken);
   c_pattern: cover property (ext_ctrl.pattern_output_enable);
   c_invert: cover property (trim.sample_clock_invert);
endmodule : aecr_regs_properties
bind aecr_regs aecr_regs_properties aecr_regs_properties_inst (.clk,
   .rst_n, .extended_mode, .serial_select_n, .ext_ctrl, .trim,
   .output_data_clock_keep, .frame_taken);
`default_nettype wire

// >>> testbench/aecr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module aecr_host_model (
   input wire logic clk,
   output logic sclk = 1'b0,
   output logic sel_n = 1'b1,
   output logic sdi = 1'b1
);
   // The shift clock rests low between frames and released data flips,
   // so a late sample cannot match by chance.
   task automatic shift(input logic [31:0] f, input int n);
      sel_n <= 1'b0;
      for (int i = 31; i > 31 - n; i--) begin
         sdi <= f[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
      end
      sdi <= ~sdi;
   endtask : shift
   task automatic release_sel();
      sel_n <= 1'b1;
      sdi <= ~sdi;
      repeat (8) @(posedge clk);
   endtask : release_sel
endmodule : aecr_host_model
`default_nettype wire

// >>> testbench/aecr_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module aecr_regs_tb
   import aecr_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, mode = 1'b1, pd = 1'b0;
   wire sclk, sel_n, sdi;
   aecr_ext_s ext;
   aecr_trim_s trm;
   logic keep, tk;
   int err_total = 0, checks_done = 0, pulses = 0, cyc = 0;
   logic [3:0] al [6] = '{4'h3, 4'h9, 4'ha, 4'hb, 4'he, 4'hf};
   logic [15:0] df [16] = '{3: 16'h807f, 9: 16'h03ff, 10: 16'h007f,
      11: 16'h807f, 14: 16'h00ff, 15: 16'h007f, default: 16'hffff};
   logic [15:0] sh [16];
   aecr_regs aecr_regs_inst (.clk, .rst_n, .extended_mode(mode),
      .power_down(pd), .serial_shift_clk(sclk), .serial_select_n(sel_n),
      .serial_input_line(sdi), .ext_ctrl(ext), .trim(trm),
      .output_data_clock_keep(keep), .frame_taken(tk));
   aecr_host_model host (.clk, .sclk, .sel_n, .sdi);
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (tk === 1'b1) pulses <= pulses + 1;
      if (cyc == 12000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string what, input logic [63:0] exp, act);
      checks_done++;
      if (act !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, act);
      end
   endtask : chk
   // Outside extended mode the outputs show defaults, yet contents stay.
   function automatic logic [15:0] g(input int a);
      return mode ? sh[a] : df[a];
   endfunction : g
   function automatic logic [15:0] fill(input logic [3:0] a,
      input logic [15:0] d);
      logic [15:0] v;
      v = d;
      if ((a == 4'h3 || a == 4'hb)
         && !(v[15:7] inside {[9'h0c0:9'h1c0]})) begin
         // Random gain codes stay inside the recommended band.
         v[15:7] = 9'h0c0 + 9'(v[13:7]);
      end
      if (a == 4'h9) return (v | 16'h03ff) & 16'hf7ff;
      return v | ((a == 4'he) ? 16'h00ff : 16'h007f);
   endfunction : fill
   task automatic cmp();
      logic [79:0] w;
      logic [43:0] t;
      logic [15:0] x;
      w = {g(3), g(11), g(10), g(14), g(15)};
      t = {w[79:71], w[63:55], w[47:39], w[31:24], w[15:7]};
      x = g(9);
      chk("trim", t, trm);
      chk("setup", {x[15:12], x[10], x[14]}, {ext, keep});
   endtask : cmp
   task automatic wr(input logic [3:0] a, input logic [15:0] d,
      input int n = 32, input logic [11:0] h = 12'h001);
      int p0;
      logic ok;
      p0 = pulses;
      ok = n == 32 && h == 12'h001 && mode;
      host.shift({h, a, d}, n);
      repeat (12) @(posedge clk);
      if (ok && a inside {al}) sh[a] = d;
      chk("pulses", 64'(ok), 64'(pulses - p0));
      cmp();
   endtask : wr
   initial begin
      logic [3:0] a;
      void'($urandom(32'h97e2));
      sh = df;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      cmp();
      $display("reset test done");
      wr(4'h3, 16'h007f);
      wr(4'hb, 16'hffff);
      wr(4'he, 16'h80ff);
      for (int i = 0; i < 12; i++) begin
         a = al[$urandom_range(5, 0)];
         wr(a, fill(a, 16'($urandom)));
      end
      wr(4'h9, 16'hf7ff);
      $display("write test done");
      wr(4'h5, 16'hffff);
      wr(4'h3, 16'hffff, 32, 12'h003);
      wr(4'h3, 16'hffff, 20);
      host.release_sel();
      wr(4'hf, 16'hff7f);
      $display("refusal test done");
      // The mode pin is synchronised, so allow it time to reach outputs.
      mode <= 1'b0;
      pd <= 1'b1;
      repeat (8) @(posedge clk);
      cmp();
      wr(4'he, 16'h12ff);
      mode <= 1'b1;
      repeat (8) @(posedge clk);
      cmp();
      pd <= 1'b0;
      $display("mode test done");
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      sh = df;
      repeat (4) @(posedge clk);
      cmp();
      wr(4'ha, 16'hff7f);
      $display("second reset done");
      tally_and_finish();
   end
endmodule : aecr_regs_tb
`default_nettype wire
